// File: rtl/pus_power_up_sequencer.sv
// Power-up sequencer: supply qualification, off modes, slot sequencer,
// standby/run handling and its APB register file.
// Assumes monitors and the on/off pin are asynchronous; fuse data is static.
`timescale 1ns/1ps
module pus_power_up_sequencer #(
  parameter int unsigned FUSE_CYC = pus_pkg::FUSE_CYC,
  parameter int unsigned STEST_CYC = pus_pkg::STEST_CYC,
  parameter int unsigned DBNC_CYC = pus_pkg::DBNC_CYC,
  parameter int unsigned TB0_CYC = pus_pkg::TB0_CYC,
  parameter int unsigned TB1_CYC = pus_pkg::TB1_CYC,
  parameter int unsigned TB2_CYC = pus_pkg::TB2_CYC,
  parameter int unsigned TB3_CYC = pus_pkg::TB3_CYC
)(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic onOffPin, // On/off pin
  input wire pus_pkg::pus_mon_t monAsync, // Analogue monitors
  input wire pus_pkg::pus_fuse_t fuseIn, // Fuse array contents
  output logic [pus_pkg::N_REG-1:0] regEn, // Regulator enables
  output logic pgoodOut, // Power-good pin as GPO
  output logic hostResetN, // Host reset, low = held
  output logic fuseDone, // Mirror loaded
  output logic stestDone // Self-test passed
);
  localparam int TW = pus_pkg::TW;
  localparam int NR = pus_pkg::N_REG;
  localparam int NM = pus_pkg::N_MEM;
  localparam int PG = pus_pkg::PG_IDX;
  localparam int RI = pus_pkg::RST_IDX;
  localparam logic [TW-1:0] T_FUSE = TW'(FUSE_CYC - 1);
  localparam logic [TW-1:0] T_STEST = TW'(STEST_CYC - 1);
  localparam logic [TW-1:0] T_DBNC = TW'(DBNC_CYC - 1);

  function automatic logic [7:0] maxCode(input logic [NM-1:0][7:0] s, input int n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < n; i++)
      if (s[i] > m)
        m = s[i];
    return m;
  endfunction

  function automatic logic slotHit(input logic [7:0] code, input logic [7:0] cnt);
    return (code != 8'h00) && (code - 8'h01 == cnt);
  endfunction

  pus_pkg::pus_state_t state;
  pus_pkg::pus_state_t prevState;
  pus_pkg::pus_state_t offDest;
  pus_pkg::pus_mon_t monMeta;
  pus_pkg::pus_mon_t mon;
  pus_pkg::pus_fuse_t mirror;
  logic [1:0] pinSync;
  logic pinPrev;
  logic pinLvl;
  logic [TW-1:0] tmr;
  logic [TW-1:0] dbncCnt;
  logic [TW-1:0] tbCyc;
  logic [TW-1:0] age;
  logic [TW-1:0] curAge;
  logic [7:0] slotCnt;
  logic [7:0] lastCode;
  logic [7:0] endCode;
  logic [NM-1:0][7:0] slot;
  logic [1:0] tbase;
  logic [NR-1:0] stbyMask;
  logic [NR-1:0] runSet;
  logic [NR-1:0] zeroReg;
  logic lpmOff, stbyReq, doneFlag, dbncArm, dbncDone, puOk, offReq, puEvent, seqGo, slaveGo;
  logic tick, regDoneEv, seqEndEv, needSeq, wakeDirect, setDone, offState, sysOn;
  logic apbAcc, apbWr, mapped, aCtrl, aTbase, aMask, aStat, inSlot;
  logic [11:0] slotOfs;
  logic [9:0] slotIdx;
  logic [31:0] rdVal;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Pin and monitors are asynchronous to sys_clk
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinSync <= 2'h0;
      pinPrev <= 1'b0;
      monMeta <= '0;
      mon <= '0;
    end
    else
    begin
      pinSync <= {pinSync[0], onOffPin};
      pinPrev <= pinSync[1];
      monMeta <= monAsync;
      mon <= monMeta;
    end
  end

  assign pinLvl = pinSync[1];
  assign offState = (state == pus_pkg::ST_LPOFF) || (state == pus_pkg::ST_OFF);
  assign sysOn = state inside {pus_pkg::ST_SEQ, pus_pkg::ST_RUN, pus_pkg::ST_STBY};
  assign offDest = lpmOff ? pus_pkg::ST_OFF : pus_pkg::ST_LPOFF;

  assign puOk = mon.vinUv && !mon.thermSd && !(mon.ovHigh && mirror.ovloEn && mirror.ovloSdwn)
    && !mon.trimFault && !mon.fuseFault && !mon.stestFault;
  // Level mode powers down on pin low; edge-mode turn-off is not handled here
  assign offReq = !puOk || (!mirror.pinMode && !pinLvl);
  assign dbncDone = dbncArm && !pinLvl && (dbncCnt == T_DBNC);
  assign puEvent = offState && puOk && (mirror.pinMode ? dbncDone : pinLvl);
  assign seqGo = ((state == pus_pkg::ST_OFF) && puEvent)
    || ((state == pus_pkg::ST_STEST) && puOk && (tmr == T_STEST));

  assign lastCode = maxCode(slot, RI);
  assign endCode = maxCode(slot, NM);
  assign slaveGo = seqGo && (lastCode == 8'h00);

  always_comb
  begin
    case (tbase)
      2'h0: tbCyc = TW'(TB0_CYC - 1);
      2'h1: tbCyc = TW'(TB1_CYC - 1);
      2'h2: tbCyc = TW'(TB2_CYC - 1);
      default: tbCyc = TW'(TB3_CYC - 1);
    endcase
  end

  always_comb
  begin
    for (int i = 0; i < NR; i++)
      runSet[i] = slot[i] != 8'h00;
  end

  assign zeroReg = ~runSet;
  assign tick = (state == pus_pkg::ST_SEQ) && !offReq && (tmr == tbCyc);
  assign regDoneEv = tick && (lastCode != 8'h00) && (slotCnt == lastCode - 8'h01);
  assign seqEndEv = tick && (slotCnt == endCode - 8'h01);
  assign needSeq = |(runSet & ~regEn);
  assign wakeDirect = (state == pus_pkg::ST_STBY) && !stbyReq && !offReq && !needSeq;
  assign setDone = regDoneEv || slaveGo || wakeDirect;

  always_ff @(posedge sys_clk)
  begin
    if (rst || pinLvl)
    begin
      dbncArm <= 1'b0;
      dbncCnt <= '0;
    end
    else if (pinPrev)
    begin
      dbncArm <= 1'b1;
      dbncCnt <= '0;
    end
    else if (dbncArm)
    begin
      dbncCnt <= dbncCnt + TW'(1);
      if (dbncDone)
        dbncArm <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !mon.vinUv)
    begin
      state <= pus_pkg::ST_UNPWR;
      tmr <= '0;
      slotCnt <= 8'h00;
    end
    else
    begin
      tmr <= tmr + TW'(1);
      case (state)
        pus_pkg::ST_UNPWR:
        begin
          state <= pus_pkg::ST_FUSE;
          tmr <= '0;
        end
        pus_pkg::ST_FUSE:
          if (tmr == T_FUSE)
            state <= pus_pkg::ST_LPOFF;
        pus_pkg::ST_LPOFF, pus_pkg::ST_OFF:
        begin
          tmr <= '0;
          slotCnt <= 8'h00;
          if (puEvent && (state == pus_pkg::ST_LPOFF))
            state <= pus_pkg::ST_STEST;
          else if (seqGo)
            state <= slaveGo ? pus_pkg::ST_RUN : pus_pkg::ST_SEQ;
        end
        pus_pkg::ST_STEST:
          if (!puOk)
            state <= offDest;
          else if (seqGo)
          begin
            state <= slaveGo ? pus_pkg::ST_RUN : pus_pkg::ST_SEQ;
            tmr <= '0;
          end
        pus_pkg::ST_SEQ:
          if (offReq)
            state <= offDest;
          else if (tick)
          begin
            tmr <= '0;
            slotCnt <= slotCnt + 8'h01;
            if (seqEndEv)
              state <= pus_pkg::ST_RUN;
          end
        pus_pkg::ST_RUN:
          if (offReq)
            state <= offDest;
          else if (stbyReq)
            state <= pus_pkg::ST_STBY;
        pus_pkg::ST_STBY:
          if (offReq)
            state <= offDest;
          else if (!stbyReq)
          begin
            state <= needSeq ? pus_pkg::ST_SEQ : pus_pkg::ST_RUN;
            tmr <= '0;
            slotCnt <= 8'h00;
          end
        default: state <= pus_pkg::ST_UNPWR;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mirror <= '0;
    else if ((state == pus_pkg::ST_FUSE) && (tmr == T_FUSE))
      mirror <= fuseIn;
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge sys_clk)
  begin
    if (rst || (state == pus_pkg::ST_UNPWR))
    begin
      fuseDone <= 1'b0;
      stestDone <= 1'b0;
      doneFlag <= 1'b0;
    end
    else
    begin
      if ((state == pus_pkg::ST_FUSE) && (tmr == T_FUSE))
        fuseDone <= 1'b1;
      if ((state == pus_pkg::ST_STEST) && seqGo)
        stestDone <= 1'b1;
      if (setDone)
        doneFlag <= 1'b1;
      else if (apbWr && aStat && pwdata[pus_pkg::STAT_DONE])
        doneFlag <= 1'b0;
    end
  end

  assign apbAcc = psel && penable && !pready;
  assign apbWr = psel && penable && pready && pwrite;
  assign aCtrl = paddr == pus_pkg::OFF_CTRL;
  assign aTbase = paddr == pus_pkg::OFF_TBASE;
  assign aMask = paddr == pus_pkg::OFF_MASK;
  assign aStat = paddr == pus_pkg::OFF_STAT;
  assign slotOfs = paddr - pus_pkg::OFF_SLOT;
  assign slotIdx = slotOfs[11:2];
  assign inSlot = (paddr >= pus_pkg::OFF_SLOT) && (slotOfs < 12'(4 * NM))
    && (paddr[1:0] == 2'h0);

  always_ff @(posedge sys_clk)
  begin
    if (rst || (state == pus_pkg::ST_UNPWR))
    begin
      lpmOff <= 1'b0;
      stbyReq <= 1'b0;
      stbyMask <= '0;
    end
    else
    begin
      if (apbWr && aCtrl && (state == pus_pkg::ST_RUN))
        lpmOff <= pwdata[pus_pkg::CTRL_LPM];
      if (apbWr && aCtrl)
        stbyReq <= pwdata[pus_pkg::CTRL_STBY];
      if (apbWr && aMask)
        stbyMask <= pwdata[NR-1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tbase <= pus_pkg::RST_TBASE;
      slot <= {NM{pus_pkg::RST_SLOT}};
    end
    else if (offState)
    begin
      tbase <= mirror.tbase;
      slot <= mirror.slot;
    end
    else if (apbWr && sysOn)
    begin
      if (aTbase)
        tbase <= pwdata[1:0];
      if (inSlot)
        slot[slotIdx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !sysOn)
    begin
      regEn <= '0;
      pgoodOut <= 1'b0;
      hostResetN <= !rst && slaveGo;
    end
    else if ((state == pus_pkg::ST_RUN) && stbyReq && !offReq)
      regEn <= regEn & stbyMask;
    else if (state == pus_pkg::ST_SEQ && !offReq)
    begin
      for (int i = 0; i < NR; i++)
        if (slotHit(slot[i], slotCnt))
          regEn[i] <= 1'b1;
      if (slotHit(slot[PG], slotCnt))
        pgoodOut <= 1'b1;
      if (slotHit(slot[RI], slotCnt) || (regDoneEv && (slot[RI] == 8'h00)))
        hostResetN <= 1'b1;
    end
  end

  always_comb
  begin
    rdVal = 32'h0000_0000;
    mapped = 1'b1;
    if (aCtrl)
    begin
      rdVal[pus_pkg::CTRL_LPM] = lpmOff;
      rdVal[pus_pkg::CTRL_STBY] = stbyReq;
    end
    else if (aTbase)
      rdVal[1:0] = tbase;
    else if (aMask)
      rdVal[NR-1:0] = stbyMask;
    else if (aStat)
    begin
      rdVal[pus_pkg::STAT_DONE] = doneFlag;
      rdVal[pus_pkg::STAT_FUSE] = fuseDone;
      rdVal[pus_pkg::STAT_STEST] = stestDone;
      rdVal[pus_pkg::STAT_SEQ] = state == pus_pkg::ST_SEQ;
      rdVal[pus_pkg::STAT_RUN] = state == pus_pkg::ST_RUN;
      rdVal[pus_pkg::STAT_STBY] = state == pus_pkg::ST_STBY;
      rdVal[pus_pkg::STAT_OFF] = offState;
    end
    else if (inSlot)
      rdVal[7:0] = slot[slotIdx];
    else
      mapped = 1'b0;
  end

  // One wait state keeps decode off the ready path
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apbAcc;
      pslverr <= apbAcc && !mapped;
      prdata <= (apbAcc && !pwrite) ? rdVal : 32'h0000_0000;
    end
  end

  // Cycles already spent in the current state; zero in its first cycle
  assign curAge = (state != prevState) ? '0 : age;
  always_ff @(posedge sys_clk)
  begin
    prevState <= state;
    age <= rst ? '0 : curAge + TW'(1);
  end

  property p_lpm_clear;
    state == pus_pkg::ST_UNPWR |=> !lpmOff;
  endproperty
  a_lpm_clear: assert property (p_lpm_clear)
    else $error("low-power off select not cleared");

  property p_lpm_hold;
    !(state inside {pus_pkg::ST_RUN, pus_pkg::ST_UNPWR}) |=> lpmOff == $past(lpmOff);
  endproperty
  a_lpm_hold: assert property (p_lpm_hold)
    else $error("low-power off select changed outside run");

  property p_fuse_time;
    state == pus_pkg::ST_FUSE |-> curAge < FUSE_CYC;
  endproperty
  a_fuse_time: assert property (p_fuse_time)
    else $error("fuse load too long");

  property p_stest_time;
    state == pus_pkg::ST_STEST |-> curAge < STEST_CYC;
  endproperty
  a_stest_time: assert property (p_stest_time)
    else $error("self-test too long");

  property p_first_slot;
    $rose(stestDone) |-> state inside {pus_pkg::ST_SEQ, pus_pkg::ST_RUN};
  endproperty
  a_first_slot: assert property (p_first_slot)
    else $error("sequence did not start after self-test");

  property p_reject;
    offState && !puOk |=> !(state inside {pus_pkg::ST_STEST, pus_pkg::ST_SEQ, pus_pkg::ST_RUN});
  endproperty
  a_reject: assert property (p_reject)
    else $error("power-up accepted while not qualified");

  property p_zero_slot;
    !(|(regEn & ~$past(regEn) & $past(zeroReg)));
  endproperty
  a_zero_slot: assert property (p_zero_slot)
    else $error("regulator with zero slot enabled");

  property p_slot_step;
    tick && !seqEndEv |=> state == pus_pkg::ST_SEQ && slotCnt == $past(slotCnt) + 8'h01;
  endproperty
  a_slot_step: assert property (p_slot_step)
    else $error("slot counter did not advance");

  property p_slave;
    slaveGo |=> state == pus_pkg::ST_RUN && regEn == '0 && !pgoodOut && hostResetN;
  endproperty
  a_slave: assert property (p_slave)
    else $error("slave mode entry wrong");

  property p_done;
    regDoneEv && slot[RI] == 8'h00 |=> doneFlag && hostResetN;
  endproperty
  a_done: assert property (p_done)
    else $error("done flag or reset release missing");

  property p_wake;
    wakeDirect |=> state == pus_pkg::ST_RUN ##0 doneFlag;
  endproperty
  a_wake: assert property (p_wake)
    else $error("direct wake did not flag done");
endmodule

// File: rtl/pus_pkg.sv
// Shared constants and types of the power-up sequencer.
// Assumes a 250 MHz sys_clk and a 32-bit APB master.
package pus_pkg;
  localparam int N_REG = 6;
  localparam int N_MEM = N_REG + 2;
  localparam int PG_IDX = N_REG;
  localparam int RST_IDX = N_REG + 1;
  localparam int TW = 18;

  localparam int CLK_MHZ = 250;
  localparam int FUSE_US = 600;
  localparam int STEST_US = 700;
  localparam int DBNC_US = 1000;
  localparam int TB0_US = 30;
  localparam int TB1_US = 120;
  localparam int TB2_US = 250;
  localparam int TB3_US = 500;
  localparam int FUSE_CYC = FUSE_US * CLK_MHZ;
  localparam int STEST_CYC = STEST_US * CLK_MHZ;
  localparam int DBNC_CYC = DBNC_US * CLK_MHZ;
  localparam int TB0_CYC = TB0_US * CLK_MHZ;
  localparam int TB1_CYC = TB1_US * CLK_MHZ;
  localparam int TB2_CYC = TB2_US * CLK_MHZ;
  localparam int TB3_CYC = TB3_US * CLK_MHZ;

  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_TBASE = 12'h004;
  localparam logic [11:0] OFF_MASK = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [11:0] OFF_SLOT = 12'h020;
  localparam int CTRL_LPM = 0;
  localparam int CTRL_STBY = 1;
  localparam int STAT_DONE = 0;
  localparam int STAT_FUSE = 1;
  localparam int STAT_STEST = 2;
  localparam int STAT_SEQ = 3;
  localparam int STAT_RUN = 4;
  localparam int STAT_STBY = 5;
  localparam int STAT_OFF = 6;
  localparam logic [1:0] RST_TBASE = 2'h0;
  localparam logic [7:0] RST_SLOT = 8'h00;

  typedef enum {ST_UNPWR, ST_FUSE, ST_LPOFF, ST_OFF, ST_STEST, ST_SEQ, ST_RUN, ST_STBY}
    pus_state_t;

  typedef struct packed {
    logic vinUv;
    logic ovHigh;
    logic thermSd;
    logic trimFault;
    logic fuseFault;
    logic stestFault;
  } pus_mon_t;

  typedef struct packed {
    logic pinMode;
    logic ovloEn;
    logic ovloSdwn;
    logic [1:0] tbase;
    logic [N_MEM-1:0][7:0] slot;
  } pus_fuse_t;
endpackage

// File: bench/pus_rail_model.sv
// Rails and host reset input on the far side of the sequencer.
// Assumes enables come from sys_clk flops; a rail settles RAMP cycles after enable.
`timescale 1ns/1ps
module pus_rail_model #(
  parameter int RAMP = 2
)(
  input wire logic sys_clk, // Reference clock
  input wire logic [pus_pkg::N_REG-1:0] regEn, // Rail enables
  input wire logic hostResetN, // Host reset input
  output logic [pus_pkg::N_REG-1:0] railUp, // Rail in regulation
  output logic hostRunning // Host out of reset
);
  logic [pus_pkg::N_REG-1:0] hist [RAMP];
  always_ff @(posedge sys_clk)
  begin
    hist[0] <= regEn;
    for (int i = 1; i < RAMP; i++)
    begin
      hist[i] <= hist[i-1];
    end
  end
  // A rail collapses at once when disabled but needs the full ramp to come up
  assign railUp = hist[RAMP-1] & regEn;
  assign hostRunning = hostResetN;
endmodule

// File: bench/power_up_sequencer_test.sv
// Self-checking bench of the power-up sequencer with shortened counts.
// Assumes the APB slave answers with one wait state and fuse data is static.
`timescale 1ns/1ps
module power_up_sequencer_test;
  localparam int FC = 20;
  localparam int SC = 30;
  localparam int DC = 10;
  localparam int T1 = 6;
  logic sys_clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic onOffPin = 0;
  pus_pkg::pus_mon_t mon = '0;
  pus_pkg::pus_fuse_t fuse = '0;
  logic [5:0] regEn;
  logic pgoodOut, hostResetN, fuseDone, stestDone, hostRunning;
  logic [5:0] railUp;
  logic [9:0] obs;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;

  pus_power_up_sequencer #(.FUSE_CYC(FC), .STEST_CYC(SC), .DBNC_CYC(DC),
    .TB0_CYC(4), .TB1_CYC(T1), .TB2_CYC(8), .TB3_CYC(10)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .onOffPin(onOffPin), .monAsync(mon), .fuseIn(fuse), .regEn(regEn), .pgoodOut(pgoodOut),
    .hostResetN(hostResetN), .fuseDone(fuseDone), .stestDone(stestDone));
  pus_rail_model rail_u (.sys_clk(sys_clk), .regEn(regEn), .hostResetN(hostResetN),
    .railUp(railUp), .hostRunning(hostRunning));

  assign obs = {hostResetN, pgoodOut, regEn, stestDone, fuseDone};
  always #2 sys_clk = ~sys_clk;

  // Whole run needs about 600 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task chk_rng(string name, int lo, int hi, int got);
    checks_done++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // Sees values as flops do: read right after the edge, before its updates
  task waitb(int idx, logic val, int lim, output int n);
    n = 0;
    while (obs[idx] !== val && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(logic [11:0] a, logic [31:0] exp, logic [31:0] mask, string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd & mask);
  endtask

  task t_bringup();
    int n;
    mon.vinUv <= 1'b1;
    waitb(0, 1'b1, FC + 12, n);
    chk_rng("fuse load time", FC, FC + 8, n);
    repeat (2) @(posedge sys_clk);
    rchk(pus_pkg::OFF_CTRL, 32'h0, 32'h1, "lpmOff");
    rchk(pus_pkg::OFF_TBASE, {30'h0, fuse.tbase}, 32'h3, "tbase default");
    rchk(pus_pkg::OFF_SLOT, {24'h0, fuse.slot[0]}, 32'hFF, "slot default");
  endtask

  task t_level();
    int n;
    onOffPin <= 1'b1;
    waitb(1, 1'b1, SC + 12, n);
    chk_rng("selftest time", SC, SC + 8, n);
    waitb(2, 1'b1, 4, n);
    chk_rng("first slot", 0, 3, n);
    t0 = cyc;
    waitb(8, 1'b1, 3 * T1, n);
    chk_rng("gpo slot", T1, T1, cyc - t0);
    waitb(3, 1'b1, 3 * T1, n);
    chk_rng("slot two", 2 * T1, 2 * T1, cyc - t0);
    waitb(9, 1'b1, 3 * T1, n);
    chk_rng("host release", 3 * T1 - 2, 3 * T1 + 2, cyc - t0);
    chk("rails", 32'h3, {26'h0, regEn});
    chk("rails settled", 32'h3, {26'h0, railUp});
    chk("host running", 32'h1, {31'h0, hostRunning});
    rchk(pus_pkg::OFF_STAT, 32'h17, 32'h7F, "status run");
  endtask

  task t_writes();
    apb(1'b1, pus_pkg::OFF_CTRL, 32'h1);
    rchk(pus_pkg::OFF_CTRL, 32'h1, 32'h3, "lpmOff write");
    apb(1'b1, pus_pkg::OFF_TBASE, 32'h3);
    rchk(pus_pkg::OFF_TBASE, 32'h3, 32'hFFFFFFFF, "tbase write");
    apb(1'b1, pus_pkg::OFF_SLOT, 32'h5);
    rchk(pus_pkg::OFF_SLOT, 32'h5, 32'hFFFFFFFF, "slot write");
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
  endtask

  task t_off_qualify();
    int n;
    onOffPin <= 1'b0;
    waitb(9, 1'b0, 8, n);
    rchk(pus_pkg::OFF_TBASE, 32'h1, 32'h3, "tbase reload");
    rchk(pus_pkg::OFF_SLOT, 32'h1, 32'hFF, "slot reload");
    rchk(pus_pkg::OFF_CTRL, 32'h1, 32'h1, "lpmOff kept");
    onOffPin <= 1'b1;
    // Every fault term in turn, supply kept good
    for (int i = 0; i < 5; i++)
    begin
      mon <= pus_pkg::pus_mon_t'(6'h20 | (6'h01 << i));
      repeat (30) @(posedge sys_clk);
      chk("blocked", 32'h0, {24'h0, obs[9:2]});
    end
    mon <= pus_pkg::pus_mon_t'(6'h20);
    waitb(2, 1'b1, 12, n);
    chk_rng("wake from off", 2, 8, n);
    waitb(9, 1'b1, 4 * T1, n);
  endtask

  task t_stby(logic [31:0] mask, logic [31:0] expStby);
    apb(1'b1, pus_pkg::OFF_STAT, 32'h1);
    apb(1'b1, pus_pkg::OFF_MASK, mask);
    apb(1'b1, pus_pkg::OFF_CTRL, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk("standby rails", expStby, {26'h0, regEn});
    rchk(pus_pkg::OFF_STAT, 32'h20, 32'h31, "standby status");
    apb(1'b1, pus_pkg::OFF_CTRL, 32'h1);
    repeat (3 * T1 + 6) @(posedge sys_clk);
    chk("woken rails", 32'h3, {26'h0, regEn});
    rchk(pus_pkg::OFF_STAT, 32'h11, 32'h31, "wake done");
  endtask

  task t_edge_slave();
    int n;
    mon <= '0;
    repeat (6) @(posedge sys_clk);
    chk("supply loss", 32'h0, {24'h0, obs[9:2]});
    fuse.pinMode <= 1'b1;
    fuse.slot <= '0;
    t_bringup();
    // A low pulse shorter than the debounce must be ignored
    onOffPin <= 1'b0;
    repeat (DC - 4) @(posedge sys_clk);
    onOffPin <= 1'b1;
    repeat (SC + 20) @(posedge sys_clk);
    chk("short pulse", 32'h0, {31'h0, hostResetN});
    onOffPin <= 1'b0;
    waitb(9, 1'b1, DC + SC + 24, n);
    chk_rng("edge wake", DC + SC, DC + SC + 14, n);
    chk("slave outputs", 32'h0, {25'h0, obs[8:2]});
    rchk(pus_pkg::OFF_STAT, 32'h10, 32'h78, "slave run");
  endtask

  initial
  begin
    fuse.tbase = 2'h1;
    fuse.ovloEn = 1'b1;
    fuse.ovloSdwn = 1'b1;
    fuse.slot[0] = 8'h01;
    fuse.slot[1] = 8'h03;
    fuse.slot[6] = 8'h02;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_bringup();
    t_level();
    t_writes();
    t_off_qualify();
    t_stby(32'h0, 32'h0);
    t_stby(32'h3F, 32'h3);
    t_edge_slave();
    conclude();
  end
endmodule
